// File: sim/acr_atomic_req_assertions.sv
// Checker for the atomic request output, the memory strobe and the pin enables.
`timescale 1ns/1ps
module acr_atomic_req_checker (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_cpu_lock_n,
   input wire i_mem_cycle_req,
   input wire i_mem_cycle_write,
   input wire i_probe_window_end_n,
   input wire i_fill_excl,
   input wire i_cpu_addr_drive,
   input wire i_line_addr_out_en_n,
   input wire o_membus_cycle_strobe_n,
   input wire o_mem_cycle_write,
   input wire o_atomic_request_n,
   input wire o_protocol_addr_lock,
   input wire o_cpu_addr_oe,
   input wire o_mem_addr_oe
);
   // ==========================================================
   // All checks run on the system clock and rest during reset.
   // ==========================================================
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   rst_idle_a: assert property (!$past(i_rst_n) |-> o_atomic_request_n)
      else $error("atomic request active right after reset");
   strobe_follows_a: assert property (1 |=> o_membus_cycle_strobe_n == !$past(i_mem_cycle_req))
      else $error("memory strobe not one clock after its request");
   write_attr_a: assert property (i_mem_cycle_req |=> o_mem_cycle_write == $past(i_mem_cycle_write))
      else $error("write attribute not valid with the strobe");
   fall_with_strobe_a: assert property ($fell(o_atomic_request_n) |-> !o_membus_cycle_strobe_n)
      else $error("atomic request went active without a strobe");
   no_req_idle_a: assert property (o_atomic_request_n && !i_mem_cycle_req |=> o_atomic_request_n)
      else $error("atomic request raised with no memory cycle");
   rise_off_strobe_a: assert property ($rose(o_atomic_request_n) |-> o_membus_cycle_strobe_n)
      else $error("atomic request released at a strobe");
   addr_lock_hold_a: assert property (o_protocol_addr_lock && !o_atomic_request_n && !i_cpu_lock_n
      |=> !o_atomic_request_n)
      else $error("atomic request dropped while the lock was held");
   addr_lock_rel_a: assert property (o_protocol_addr_lock && !o_atomic_request_n && i_cpu_lock_n
      && !i_mem_cycle_req |=> o_atomic_request_n)
      else $error("atomic request not released one clock after unlock");
   excl_release_a: assert property (!o_atomic_request_n && !i_probe_window_end_n && i_fill_excl
      |-> ##2 !o_atomic_request_n ##1 o_atomic_request_n)
      else $error("exclusive fill release not two clocks after window end");
   mem_oe_a: assert property (1 |=> o_mem_addr_oe == !$past(i_line_addr_out_en_n))
      else $error("memory pin enable does not follow its input");
   cpu_oe_a: assert property (1 |=> o_cpu_addr_oe == $past(i_cpu_addr_drive))
      else $error("processor pin enable does not follow its input");
endmodule
bind acr_atomic_req acr_atomic_req_checker acr_atomic_req_checker_inst (
   .i_ref_clk, .i_rst_n, .i_cpu_lock_n, .i_mem_cycle_req, .i_mem_cycle_write, .i_probe_window_end_n,
   .i_fill_excl, .i_cpu_addr_drive, .i_line_addr_out_en_n, .o_membus_cycle_strobe_n, .o_mem_cycle_write,
   .o_atomic_request_n, .o_protocol_addr_lock, .o_cpu_addr_oe, .o_mem_addr_oe);

// File: sim/acr_atomic_req_tb.sv
// Self-checking testbench for the atomic cycle request logic.
`timescale 1ns/1ps
`include "acr_defines.vh"
module acr_atomic_req_tb;
   // ========================================================
   // Stimulus registers, observed outputs and resolved pins.
   // ========================================================
   reg         clk, rst_n, strap, lock_n, split, cs_n, wr, wend_n, fexcl, req, mwr, drv, aoe_n, ale, probe;
   reg  [1:0]  ls;
   reg  [29:0] maddr, cval, cdrv, paddr;
   wire [29:0] cout, mout, ccap, pcap, ppins, cbus, mbus;
   wire        strb_n, mwr_o, atom_n, plock, coe, moe, pstb_n;
   wire [7:0]  nlock;
   integer     failures, n_checks;
   assign cbus = coe ? cout : cdrv;
   assign mbus = moe ? mout : ppins;
   acr_atomic_req acr_atomic_req_inst (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_atomic_protocol_sel(strap), .i_cpu_lock_n(lock_n),
      .i_split_cycle_ind(split), .i_cpu_addr_strobe_n(cs_n), .i_cpu_write(wr), .i_line_state(ls),
      .i_probe_window_end_n(wend_n), .i_fill_excl(fexcl), .i_mem_cycle_req(req), .i_mem_cycle_write(mwr),
      .i_mem_cycle_addr(maddr), .i_cpu_addr_drive(drv), .i_cpu_addr_val(cval),
      .i_cpu_cfg_addr_bits(cbus[4:2]), .i_cpu_index_addr(cbus[17:5]), .i_cpu_upper_addr(cbus[29:18]),
      .i_cpu_subline_sel(cbus[1:0]), .o_cpu_cfg_addr_bits(cout[4:2]), .o_cpu_index_addr(cout[17:5]),
      .o_cpu_upper_addr(cout[29:18]), .o_cpu_subline_sel(cout[1:0]), .o_cpu_addr_oe(coe), .o_cpu_cycle_addr(ccap),
      .i_line_addr_out_en_n(aoe_n), .i_line_addr_latch_en(ale), .i_coherency_probe_strobe_n(pstb_n),
      .i_mem_cfg_addr_bits(mbus[4:2]), .i_mem_index_addr(mbus[17:5]), .i_mem_upper_addr(mbus[29:18]),
      .i_mem_subline_sel(mbus[1:0]), .o_mem_cfg_addr_bits(mout[4:2]), .o_mem_index_addr(mout[17:5]),
      .o_mem_upper_addr(mout[29:18]), .o_mem_subline_sel(mout[1:0]), .o_mem_addr_oe(moe), .o_probe_addr(pcap),
      .o_membus_cycle_strobe_n(strb_n), .o_mem_cycle_write(mwr_o), .o_atomic_request_n(atom_n),
      .o_protocol_addr_lock(plock));
   acr_mbc_model acr_mbc_model_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_strobe_n(strb_n), .i_atomic_n(atom_n),
      .i_probe(probe), .i_probe_addr(paddr), .o_probe_strobe_n(pstb_n), .o_pins(ppins), .o_locked(nlock));
   // ========================================================
   // Shared tasks: compare, verdict, reset and bus cycles.
   // ========================================================
   task chk(input [29:0] exp, input [29:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0t expected %h got %h", $time, exp, got);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Reset with the strap held steady, then wait until locks are honoured.
   task do_reset(input s);
      begin
         @(posedge clk) rst_n <= 1'h0;
         strap <= s;
         repeat (8) @(posedge clk);
         rst_n <= 1'h1;
         repeat (6) @(posedge clk);
         #1 chk(1, atom_n);
         chk(s, plock);
      end
   endtask
   // Processor cycle with lock held, lasting one clock.
   task lock_go(input sp, input w, input [1:0] st);
      begin
         @(posedge clk) cs_n <= 1'h0;
         lock_n <= 1'h0;
         split <= sp;
         wr <= w;
         ls <= st;
         @(posedge clk) cs_n <= 1'h1;
      end
   endtask
   // Memory cycle request; the strobe must follow one clock later.
   task mreq(input w, input [29:0] a);
      begin
         @(posedge clk) req <= 1'h1;
         mwr <= w;
         maddr <= a;
         @(posedge clk) req <= 1'h0;
         #1 chk(0, strb_n);
         chk(w, mwr_o);
      end
   endtask
   // Drop the lock and expect the release exactly one clock later.
   task rel;
      begin
         @(posedge clk) lock_n <= 1'h1;
         #1 chk(0, atom_n);
         @(posedge clk) #1 chk(1, atom_n);
      end
   endtask
   // Leave the processor idle with lock high between sequences.
   task idle;
      begin
         @(posedge clk) lock_n <= 1'h1;
         repeat (3) @(posedge clk);
      end
   endtask
   // ========================================================
   // Scenarios.
   // ========================================================
   task t_split;
      begin
         lock_go(1, 0, `ACR_LINE_I);
         mreq(0, 30'h1234_5678);
         chk(0, atom_n);
         mreq(1, 30'h1234_5678);
         chk(0, atom_n);
         rel;
         idle;
         chk(2, nlock);
      end
   endtask
   task t_rdi;
      begin
         lock_go(0, 0, `ACR_LINE_I);
         mreq(0, 30'h0F0F_3C3C);
         chk(0, atom_n);
         @(posedge clk) wend_n <= 1'h0;
         fexcl <= 1'h1;
         @(posedge clk) wend_n <= 1'h1;
         fexcl <= 1'h0;
         @(posedge clk) #1 chk(0, atom_n);
         @(posedge clk) #1 chk(1, atom_n);
         idle;
      end
   endtask
   task t_rds;
      begin
         lock_go(0, 0, `ACR_LINE_S);
         mreq(0, 30'h2AAA_5555);
         repeat (3) @(posedge clk);
         #1 chk(0, atom_n);
         rel;
         idle;
      end
   endtask
   // Hits to exclusive and modified lines, read and write, never leave the cache.
   task t_em;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            lock_go(0, k[0], k[1] ? `ACR_LINE_M : `ACR_LINE_E);
            repeat (4) @(posedge clk);
            #1 chk(1, atom_n);
            idle;
         end
      end
   endtask
   // Lock drops before the write goes out: release waits for the write strobe.
   task t_wr;
      begin
         lock_go(0, 0, `ACR_LINE_S);
         mreq(0, 30'h3333_0CCC);
         lock_go(0, 1, `ACR_LINE_S);
         @(posedge clk) lock_n <= 1'h1;
         repeat (2) @(posedge clk);
         #1 chk(0, atom_n);
         mreq(1, 30'h3333_0CCC);
         chk(0, atom_n);
         @(posedge clk) #1 chk(1, atom_n);
         idle;
      end
   endtask
   task t_addr;
      begin
         @(posedge clk) drv <= 1'h1;
         cval <= 30'h1555_2AAA;
         aoe_n <= 1'h0;
         @(posedge clk) drv <= 1'h0;
         #1 chk(1, coe);
         chk(30'h1555_2AAA, cout);
         chk(1, moe);
         mreq(0, 30'h0ACE_1357);
         chk(30'h0ACE_1357, mout);
         @(posedge clk) ale <= 1'h0;
         mreq(0, 30'h3FFF_0000);
         chk(30'h0ACE_1357, mout);
         @(posedge clk) aoe_n <= 1'h1;
         ale <= 1'h1;
         cdrv <= 30'h2468_ACE0;
         cs_n <= 1'h0;
         @(posedge clk) cs_n <= 1'h1;
         #1 chk(30'h2468_ACE0, ccap);
         @(posedge clk) probe <= 1'h1;
         paddr <= 30'h1357_9BDF;
         @(posedge clk) probe <= 1'h0;
         @(posedge clk) #1 chk(30'h1357_9BDF, pcap);
      end
   endtask
   // Address-lock strap: even an exclusive-line lock goes out as a split sequence.
   task t_alock;
      begin
         do_reset(1);
         lock_go(0, 0, `ACR_LINE_E);
         mreq(0, 30'h0000_1111);
         chk(0, atom_n);
         rel;
      end
   endtask
   // ========================================================
   // Clock, main sequence and watchdog.
   // ========================================================
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial begin
      failures = 0;
      n_checks = 0;
      {rst_n, strap, split, wr, fexcl, req, mwr, drv, ale, probe} = 10'h002;
      {lock_n, cs_n, wend_n, aoe_n} = 4'hF;
      rst_n = 1'h0;
      ls = `ACR_LINE_I;
      {maddr, cval, cdrv, paddr} = 120'h0;
      do_reset(0);
      t_split;
      t_rdi;
      t_rds;
      t_em;
      t_wr;
      t_addr;
      t_alock;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clk);
      failures = failures + 1;
      print_verdict;
   end
endmodule

// File: sim/acr_mbc_model.sv
// Memory bus controller model: counts locked strobes and drives the snoop pins.
`timescale 1ns/1ps
module acr_mbc_model (
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   input  wire        i_strobe_n,
   input  wire        i_atomic_n,
   input  wire        i_probe,
   input  wire [29:0] i_probe_addr,
   output reg         o_probe_strobe_n,
   output reg  [29:0] o_pins,
   output reg  [7:0]  o_locked
);
   // Between probes the pins toggle every clock so stale values never look valid.
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_probe_strobe_n <= 1'h1;
         o_pins           <= 30'h0000_0000;
         o_locked         <= 8'h00;
      end else begin
         o_probe_strobe_n <= !i_probe;
         o_pins           <= i_probe ? i_probe_addr : ~o_pins;
         if (!i_strobe_n && !i_atomic_n) begin
            o_locked <= o_locked + 8'h01;
         end
      end
   end
endmodule

// File: src/acr_addr_port.v
// Address pin port: output latch with enable, input sampling, three-signal pin.
`timescale 1ns/1ps
`include "acr_defines.vh"

module acr_addr_port #(
   parameter W = `ACR_ADDR_W
) (
   input  wire         i_ref_clk,
   input  wire         i_rst_n,
   input  wire         i_load,
   input  wire [W-1:0] i_load_val,
   input  wire         i_pass,
   input  wire         i_drive,
   input  wire         i_sample,
   input  wire [W-1:0] i_pin_in,
   output reg  [W-1:0] o_pin_out,
   output reg          o_pin_oe,
   output reg  [W-1:0] o_sampled
);

   // ====================
   // Storage
   // ====================
   reg  [W-1:0] hold_r;     // Address of the newest cycle, ahead of the latch.
   wire [W-1:0] newest;     // Value that flows through when the latch is open.

   // A load and an open latch in the same cycle let the new address through.
   assign newest = i_load ? i_load_val : hold_r;

   // Holding register, output latch, pin enable and input capture.
   // Everything is on the system clock so the pins are timed to it.
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_r    <= `ACR_ADDR_RST;
         o_pin_out <= `ACR_ADDR_RST;
         o_pin_oe  <= 1'b0;
         o_sampled <= `ACR_ADDR_RST;
      end else begin
         if (i_load) begin
            hold_r <= i_load_val;
         end
         // Latch open: follow the newest address; closed: keep the old one.
         if (i_pass) begin
            o_pin_out <= newest;
         end
         o_pin_oe <= i_drive;
         // Input direction: catch the pins only while we do not drive them.
         if (i_sample && !o_pin_oe) begin
            o_sampled <= i_pin_in;
         end
      end
   end

endmodule

// File: src/acr_atomic_req.v
// Atomic cycle request logic of the second-level cache controller.
//
// Functional notes
// - Split lock: assert atomic with memory strobe.
// - Stay active through final cycle's memory strobe.
// - Release registered one clock after lock drops.
// - Cache-lock mode: assert only for memory cycles.
// - Read miss filled E or M: release two clocks after window end.
// - Shared read: release on lock drop or last strobe.
// - Exclusive or modified hit: atomic stays inactive.
// - Write S/I: release at later of both.
// - Atomic valid in same clock as strobe.
// - CPU address pins bidirectional, system clocked.
// - Memory address pins: latch, enable, clocked sampling.
// - Lock protocol strap caught at reset, then fixed.
`timescale 1ns/1ps
`include "acr_defines.vh"

module acr_atomic_req (
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   input  wire        i_atomic_protocol_sel,
   input  wire        i_cpu_lock_n,
   input  wire        i_split_cycle_ind,
   input  wire        i_cpu_addr_strobe_n,
   input  wire        i_cpu_write,
   input  wire [1:0]  i_line_state,
   input  wire        i_probe_window_end_n,
   input  wire        i_fill_excl,
   input  wire        i_mem_cycle_req,
   input  wire        i_mem_cycle_write,
   input  wire [29:0] i_mem_cycle_addr,
   input  wire        i_cpu_addr_drive,
   input  wire [29:0] i_cpu_addr_val,
   input  wire [2:0]  i_cpu_cfg_addr_bits,
   input  wire [12:0] i_cpu_index_addr,
   input  wire [11:0] i_cpu_upper_addr,
   input  wire [1:0]  i_cpu_subline_sel,
   output wire [2:0]  o_cpu_cfg_addr_bits,
   output wire [12:0] o_cpu_index_addr,
   output wire [11:0] o_cpu_upper_addr,
   output wire [1:0]  o_cpu_subline_sel,
   output wire        o_cpu_addr_oe,
   output wire [29:0] o_cpu_cycle_addr,
   input  wire        i_line_addr_out_en_n,
   input  wire        i_line_addr_latch_en,
   input  wire        i_coherency_probe_strobe_n,
   input  wire [2:0]  i_mem_cfg_addr_bits,
   input  wire [12:0] i_mem_index_addr,
   input  wire [11:0] i_mem_upper_addr,
   input  wire [1:0]  i_mem_subline_sel,
   output wire [2:0]  o_mem_cfg_addr_bits,
   output wire [12:0] o_mem_index_addr,
   output wire [11:0] o_mem_upper_addr,
   output wire [1:0]  o_mem_subline_sel,
   output wire        o_mem_addr_oe,
   output wire [29:0] o_probe_addr,
   output reg         o_membus_cycle_strobe_n,
   output reg         o_mem_cycle_write,
   output reg         o_atomic_request_n,
   output reg         o_protocol_addr_lock
);

   // ====================
   // Lock protocol strap
   // ====================
   reg        sel_meta_r;   // First synchroniser stage of the strap pin.
   reg        sel_sync_r;   // Second synchroniser stage of the strap pin.
   reg  [1:0] cfg_cnt_r;    // Edges since reset release, saturating.
   reg        cfg_done_r;   // Strap has been captured; locks may start.

   // The strap is a pin, so it passes two flops first. Its level at reset
   // release is taken once the synchroniser holds it, and kept from then on.
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_meta_r           <= 1'b0;
         sel_sync_r           <= 1'b0;
         cfg_cnt_r            <= `ACR_CNT_ZERO;
         cfg_done_r           <= 1'b0;
         o_protocol_addr_lock <= 1'b0;
      end else begin
         sel_meta_r <= i_atomic_protocol_sel;
         sel_sync_r <= sel_meta_r;
         if (!cfg_done_r) begin
            if (cfg_cnt_r == `ACR_CFG_WAIT) begin
               o_protocol_addr_lock <= sel_sync_r;
               cfg_done_r           <= 1'b1;
            end else begin
               cfg_cnt_r <= cfg_cnt_r + `ACR_CNT_ONE;
            end
         end
      end
   end

   // ====================
   // Decoded events of the current cycle
   // ====================
   wire lock_act;    // CPU lock indication is active.
   wire cpu_start;   // CPU address strobe of a locked cycle.
   wire line_em;     // Looked-up line is exclusive or modified.
   wire mem_go;      // A memory cycle strobe goes out at the next edge.
   wire excl_fill;   // Probe window ended with the line made E or M.

   // Line state decode, used for the start and for the write conversion.
   function is_em;
      input [1:0] st;
      begin
         is_em = (st == `ACR_LINE_E) || (st == `ACR_LINE_M);
      end
   endfunction

   assign lock_act  = !i_cpu_lock_n;
   assign cpu_start = !i_cpu_addr_strobe_n && lock_act;
   assign line_em   = is_em(i_line_state);
   assign mem_go    = i_mem_cycle_req;
   assign excl_fill = !i_probe_window_end_n && i_fill_excl;

   // ====================
   // Lock sequencer
   // ====================
   reg  [2:0] st_r;         // Sequencer state.
   reg  [2:0] st_nxt;
   reg  [1:0] kind_r;       // Kind of the locked sequence in progress.
   reg  [1:0] kind_nxt;
   reg        wr_done_r;    // A write memory strobe of this sequence went out.
   reg        wr_done_nxt;
   reg        gone_r;       // Lock was seen inactive during this sequence.
   reg        gone_nxt;
   reg  [1:0] cnt_r;        // Clocks left before an exclusive-fill release.
   reg  [1:0] cnt_nxt;
   reg        atom_nxt;     // Next level of the active-low atomic output.
   reg        rel_now;      // Drop the atomic request at the next edge.

   // Next-state logic. The atomic level is computed here and registered
   // with the memory strobe so that both change on the same edge.
   always @* begin
      st_nxt      = st_r;
      kind_nxt    = kind_r;
      wr_done_nxt = wr_done_r;
      gone_nxt    = gone_r;
      cnt_nxt     = cnt_r;
      atom_nxt    = o_atomic_request_n;
      rel_now     = 1'b0;
      case (st_r)
         `ACR_ST_IDLE: begin
            // A new sequence needs the lock seen idle first, which the CPU
            // guarantees with its idle clock between locked operations.
            if (cpu_start && cfg_done_r) begin
               wr_done_nxt = 1'b0;
               gone_nxt    = 1'b0;
               if (i_split_cycle_ind || o_protocol_addr_lock) begin
                  kind_nxt = `ACR_K_SPLIT;
                  st_nxt   = `ACR_ST_WAIT;
               end else if (line_em) begin
                  // Served inside the cache: no memory cycle, no request.
                  st_nxt = `ACR_ST_DRAIN;
               end else if (i_cpu_write) begin
                  kind_nxt = `ACR_K_WR;
                  st_nxt   = `ACR_ST_WAIT;
               end else if (i_line_state == `ACR_LINE_I) begin
                  kind_nxt = `ACR_K_RD_I;
                  st_nxt   = `ACR_ST_WAIT;
               end else begin
                  kind_nxt = `ACR_K_RD_S;
                  st_nxt   = `ACR_ST_WAIT;
               end
            end
         end
         `ACR_ST_WAIT: begin
            // Only a cycle that reaches the memory bus raises the request.
            if (mem_go) begin
               atom_nxt    = 1'b0;
               wr_done_nxt = i_mem_cycle_write;
               st_nxt      = `ACR_ST_ACTIVE;
            end else if (!lock_act) begin
               st_nxt = `ACR_ST_IDLE;
            end
         end
         `ACR_ST_ACTIVE: begin
            if (mem_go && i_mem_cycle_write) begin
               wr_done_nxt = 1'b1;
            end
            if (!lock_act) begin
               gone_nxt = 1'b1;
            end
            case (kind_r)
               `ACR_K_SPLIT: begin
                  // Never drop in a clock that launches a strobe, so the
                  // request covers the final cycle's strobe.
                  rel_now = !lock_act && !mem_go;
               end
               `ACR_K_RD_I: begin
                  if (excl_fill) begin
                     cnt_nxt = `ACR_EXCL_REL_CLKS;
                     st_nxt  = `ACR_ST_EXCL;
                  end else if (cpu_start && i_cpu_write && !line_em) begin
                     kind_nxt = `ACR_K_WR;
                  end else begin
                     rel_now = (!lock_act || wr_done_r) && !mem_go;
                  end
               end
               `ACR_K_RD_S: begin
                  if (cpu_start && i_cpu_write && !line_em) begin
                     kind_nxt = `ACR_K_WR;
                  end else begin
                     rel_now = (!lock_act || wr_done_r) && !mem_go;
                  end
               end
               default: begin
                  // Write to a shared or invalid line: both events needed.
                  rel_now = (gone_r || !lock_act) && wr_done_r && !mem_go;
               end
            endcase
         end
         `ACR_ST_EXCL: begin
            cnt_nxt = cnt_r - `ACR_CNT_ONE;
            rel_now = (cnt_r == `ACR_CNT_ONE);
         end
         `ACR_ST_DRAIN: begin
            // Wait for the lock to drop before a new sequence may start.
            if (!lock_act) begin
               st_nxt = `ACR_ST_IDLE;
            end
         end
         default: begin
            st_nxt = `ACR_ST_IDLE;
         end
      endcase
      if (rel_now) begin
         atom_nxt = `ACR_INACTIVE;
         st_nxt   = lock_act ? `ACR_ST_DRAIN : `ACR_ST_IDLE;
      end
   end

   // Sequencer state and the registered memory-bus cycle outputs.
   // The atomic request, strobe and write attribute share one edge.
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r                    <= `ACR_ST_IDLE;
         kind_r                  <= `ACR_K_SPLIT;
         wr_done_r               <= 1'b0;
         gone_r                  <= 1'b0;
         cnt_r                   <= `ACR_CNT_ZERO;
         o_atomic_request_n      <= `ACR_INACTIVE;
         o_membus_cycle_strobe_n <= `ACR_INACTIVE;
         o_mem_cycle_write       <= 1'b0;
      end else begin
         st_r                    <= st_nxt;
         kind_r                  <= kind_nxt;
         wr_done_r               <= wr_done_nxt;
         gone_r                  <= gone_nxt;
         cnt_r                   <= cnt_nxt;
         o_atomic_request_n      <= atom_nxt;
         o_membus_cycle_strobe_n <= !mem_go;
         if (mem_go) begin
            o_mem_cycle_write <= i_mem_cycle_write;
         end
      end
   end

   // ====================
   // CPU-side configurable address pins
   // ====================
   wire [29:0] cpu_pin_in;    // CPU address pins gathered into one word.
   wire [29:0] cpu_pin_out;   // Value this block drives onto them.

   assign cpu_pin_in = {i_cpu_upper_addr, i_cpu_index_addr,
                        i_cpu_cfg_addr_bits, i_cpu_subline_sel};

   // Driven toward the CPU on request; sampled with the CPU address strobe.
   acr_addr_port #(
      .W (`ACR_ADDR_W)
   ) u_cpu_port (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_load     (i_cpu_addr_drive),
      .i_load_val (i_cpu_addr_val),
      .i_pass     (1'b1),
      .i_drive    (i_cpu_addr_drive),
      .i_sample   (!i_cpu_addr_strobe_n),
      .i_pin_in   (cpu_pin_in),
      .o_pin_out  (cpu_pin_out),
      .o_pin_oe   (o_cpu_addr_oe),
      .o_sampled  (o_cpu_cycle_addr)
   );

   assign o_cpu_subline_sel   = cpu_pin_out[`ACR_SUB_MSB:`ACR_SUB_LSB];
   assign o_cpu_cfg_addr_bits = cpu_pin_out[`ACR_CFG_MSB:`ACR_CFG_LSB];
   assign o_cpu_index_addr    = cpu_pin_out[`ACR_IDX_MSB:`ACR_IDX_LSB];
   assign o_cpu_upper_addr    = cpu_pin_out[`ACR_UPR_MSB:`ACR_UPR_LSB];

   // ====================
   // Memory-side address pins
   // ====================
   wire [29:0] mem_pin_in;    // Memory address pins gathered into one word.
   wire [29:0] mem_pin_out;   // Value this block drives onto them.
   reg         prb_d_r;       // Probe strobe one clock ago, for edge finding.
   wire        prb_first;     // First clock of an active probe strobe.

   assign mem_pin_in = {i_mem_upper_addr, i_mem_index_addr,
                        i_mem_cfg_addr_bits, i_mem_subline_sel};
   assign prb_first  = !i_coherency_probe_strobe_n && prb_d_r;

   // The probe strobe comes from the controller on this clock.
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prb_d_r <= `ACR_INACTIVE;
      end else begin
         prb_d_r <= i_coherency_probe_strobe_n;
      end
   end

   // Latch enable opens the line-address latch; output enable drives pins.
   acr_addr_port #(
      .W (`ACR_ADDR_W)
   ) u_mem_port (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_load     (mem_go),
      .i_load_val (i_mem_cycle_addr),
      .i_pass     (i_line_addr_latch_en),
      .i_drive    (!i_line_addr_out_en_n),
      .i_sample   (prb_first),
      .i_pin_in   (mem_pin_in),
      .o_pin_out  (mem_pin_out),
      .o_pin_oe   (o_mem_addr_oe),
      .o_sampled  (o_probe_addr)
   );

   assign o_mem_subline_sel   = mem_pin_out[`ACR_SUB_MSB:`ACR_SUB_LSB];
   assign o_mem_cfg_addr_bits = mem_pin_out[`ACR_CFG_MSB:`ACR_CFG_LSB];
   assign o_mem_index_addr    = mem_pin_out[`ACR_IDX_MSB:`ACR_IDX_LSB];
   assign o_mem_upper_addr    = mem_pin_out[`ACR_UPR_MSB:`ACR_UPR_LSB];

endmodule

// File: src/acr_defines.vh
// Constants shared by the atomic cycle request logic and its address pin ports.
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ====================
// Address bus layout (CPU side and memory side use the same layout)
// ====================
`define ACR_ADDR_W        30
`define ACR_SUB_LSB       0
`define ACR_SUB_MSB       1
`define ACR_CFG_LSB       2
`define ACR_CFG_MSB       4
`define ACR_IDX_LSB       5
`define ACR_IDX_MSB       17
`define ACR_UPR_LSB       18
`define ACR_UPR_MSB       29

// ====================
// Line states as reported by the tag lookup
// ====================
`define ACR_LINE_I        2'h0
`define ACR_LINE_S        2'h1
`define ACR_LINE_E        2'h2
`define ACR_LINE_M        2'h3

// ====================
// Lock sequencer states
// ====================
`define ACR_ST_IDLE       3'h0
`define ACR_ST_WAIT       3'h1
`define ACR_ST_ACTIVE     3'h2
`define ACR_ST_EXCL       3'h3
`define ACR_ST_DRAIN      3'h4

// ====================
// Kinds of locked sequence
// ====================
`define ACR_K_SPLIT       2'h0
`define ACR_K_RD_I        2'h1
`define ACR_K_RD_S        2'h2
`define ACR_K_WR          2'h3

// ====================
// Timing and reset values
// ====================
`define ACR_EXCL_REL_CLKS 2'h2
`define ACR_CNT_ONE       2'h1
`define ACR_CFG_WAIT      2'h2
`define ACR_CNT_ZERO      2'h0
`define ACR_ADDR_RST      30'h0000_0000
`define ACR_INACTIVE      1'h1

`endif
